/* hdl/trp_true_dual_port_block_ram.sv */
// true dual-port 4096-bit block memory with independent port widths
`timescale 1ns/1ns
`default_nettype none
`include "trp_ram_regs.svh"

module trp_true_dual_port_block_ram
    import trp_ram_pkg::*;
#(
    parameter int unsigned A_W         = 16,
    parameter int unsigned B_W         = 16,
    parameter bit          SINGLE_PORT = 1'b0,
    parameter int unsigned A_AW        = $clog2(`TRP_MEM_BITS / A_W),
    parameter int unsigned B_AW        = $clog2(`TRP_MEM_BITS / B_W)
)
(
    // clock and reset
    input  wire logic            i_core_clk,
    input  wire logic            i_rst,
    // port a
    input  wire logic            i_a_clk_en,
    input  wire logic            i_a_en,
    input  wire logic            i_a_we,
    input  wire logic [A_AW-1:0] i_a_addr,
    input  wire logic [A_W-1:0]  i_a_din,
    output logic      [A_W-1:0]  o_a_dout,
    output trp_op_e              o_a_op,
    // port b, idle when built single-port
    input  wire logic            i_b_clk_en,
    input  wire logic            i_b_en,
    input  wire logic            i_b_we,
    input  wire logic [B_AW-1:0] i_b_addr,
    input  wire logic [B_W-1:0]  i_b_din,
    output logic      [B_W-1:0]  o_b_dout,
    output trp_op_e              o_b_op
);

    // widths must be 1, 2, 4, 8 or 16 and b not narrower than a;
    // other values elaborate but are not a supported shape

    ////////////////////////////////////////////////////////////////////////
    // shared storage, no reset of contents
    logic [`TRP_MEM_BITS-1:0] mem_q;

    logic      a_fire;
    logic      a_wr;
    trp_off_t  a_off;
    logic      b_fire;
    logic      b_wr;
    trp_off_t  b_off;
    logic [A_W-1:0] a_rd_word;
    logic [B_W-1:0] b_rd_word;

    assign a_rd_word = mem_q[a_off +: A_W];
    assign b_rd_word = mem_q[b_off +: B_W];

    ////////////////////////////////////////////////////////////////////////
    // ports
    trp_port_ctrl
    #(
        .W      (A_W),
        .AW     (A_AW),
        .ACTIVE (1'b1)
    )
    u_port_a
    (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_clk_en   (i_a_clk_en),
        .i_en       (i_a_en),
        .i_we       (i_a_we),
        .i_addr     (i_a_addr),
        .i_din      (i_a_din),
        .i_rd_word  (a_rd_word),
        .o_fire     (a_fire),
        .o_wr       (a_wr),
        .o_off      (a_off),
        .o_dout     (o_a_dout),
        .o_op       (o_a_op)
    );

    // single-port build keeps port b inert: no writes, output held at reset
    trp_port_ctrl
    #(
        .W      (B_W),
        .AW     (B_AW),
        .ACTIVE (!SINGLE_PORT)
    )
    u_port_b
    (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_clk_en   (i_b_clk_en),
        .i_en       (i_b_en),
        .i_we       (i_b_we),
        .i_addr     (i_b_addr),
        .i_din      (i_b_din),
        .i_rd_word  (b_rd_word),
        .o_fire     (b_fire),
        .o_wr       (b_wr),
        .o_off      (b_off),
        .o_dout     (o_b_dout),
        .o_op       (o_b_op)
    );

    ////////////////////////////////////////////////////////////////////////
    // array writes; each port writes its own sub-field with no arbitration.
    // on a same-bit collision port b lands last, but the user must not rely on it
    always_ff @(posedge i_core_clk)
    begin
        if (a_wr)
            mem_q[a_off +: A_W] <= i_a_din;
        if (b_wr)
            mem_q[b_off +: B_W] <= i_b_din;
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb_core @(posedge i_core_clk);
    endclocking

    default disable iff (i_rst);

    sequence s_a_write;
        a_fire && i_a_we;
    endsequence

    sequence s_a_read;
        a_fire && !i_a_we;
    endsequence

    sequence s_b_write;
        b_fire && i_b_we;
    endsequence

    sequence s_b_read;
        b_fire && !i_b_we;
    endsequence

    sequence s_a_quiet2;
        (!a_fire) [*2];
    endsequence

    // overlap test, used to skip write-store checks hit by the other port's write
    logic a_hit_by_b;
    logic b_hit_by_a;

    // one spare bit so the end of the top word does not wrap to zero
    assign a_hit_by_b = b_wr && ({1'b0, b_off} < {1'b0, a_off} + 13'(A_W))
                        && ({1'b0, a_off} < {1'b0, b_off} + 13'(B_W));
    assign b_hit_by_a = a_wr && ({1'b0, a_off} < {1'b0, b_off} + 13'(B_W))
                        && ({1'b0, b_off} < {1'b0, a_off} + 13'(A_W));

    chk_a_write_mirror: assert property (s_a_write |=> o_a_dout == $past(i_a_din))
        else $error("port a output does not mirror write data");

    chk_a_write_store: assert property (s_a_write ##0 !a_hit_by_b
        |=> mem_q[$past(a_off) +: A_W] == $past(i_a_din))
        else $error("port a write not stored after one edge");

    chk_a_read_data: assert property (s_a_read |=> o_a_dout == $past(a_rd_word))
        else $error("port a read word wrong after the edge");

    chk_a_hold_value: assert property (s_a_write ##1 s_a_quiet2
        |=> o_a_dout == $past(i_a_din, 3))
        else $error("port a output moved without an operation");

    chk_a_no_comb: assert property (!a_fire |=> $stable(o_a_dout))
        else $error("port a output changed without its own edge");

    chk_b_write_mirror: assert property (s_b_write |=> o_b_dout == $past(i_b_din))
        else $error("port b output does not mirror write data");

    chk_b_read_data: assert property (s_b_read |=> o_b_dout == $past(b_rd_word))
        else $error("port b read word wrong after the edge");

    chk_b_shared_store: assert property (s_b_write ##0 !b_hit_by_a
        |=> mem_q[$past(b_off) +: B_W] == $past(i_b_din))
        else $error("port b write not stored in shared array");

    chk_ports_indep: assert property (a_fire && !b_fire |=> $stable(o_b_dout))
        else $error("port a activity disturbed port b output");

    chk_op_track: assert property (s_a_read |=> o_a_op == TRP_OP_READ)
        else $error("port a operation not captured on its edge");

    chk_single_idle: assert property (b_fire |-> !SINGLE_PORT ##1 o_b_op != TRP_OP_IDLE)
        else $error("port b active in single-port build");

    chk_addr_map: assert property (a_fire |-> a_off == 12'(i_a_addr) * 12'(A_W))
        else $error("port a address maps to wrong bit offset");

    chk_glitch_free: assert property (s_b_read ##1 !b_fire |=> $stable(o_b_dout))
        else $error("port b output moved after a read");

endmodule // trp_true_dual_port_block_ram

`default_nettype wire

/* shared/trp_ram_regs.svh */
// constants of the true dual-port block memory
// Operation
// - every port input is captured only on that port's clock edge
// - output shows read data when write enable low, write data when high
// - no combinational path from address to data output
// - the two ports are independent, no arbitration between them
// - a write completes on one enabled edge with write enable high
// - a read completes on one edge, word appears after that edge
// - output holds until the same port reads or writes again
// - outputs are clean registers, never glitching
// - widths 1, 2, 4, 8, 16; single-port option; second width not narrower
// - 4096 bits of storage shared by both ports
// - read registers the stored word at the address, then drives it out
// - write stores input data and mirrors it on the output
`ifndef TRP_RAM_REGS_SVH
`define TRP_RAM_REGS_SVH

`define TRP_MEM_BITS   4096
`define TRP_OFF_BITS   12
`define TRP_MAX_WIDTH  16
`define TRP_DOUT_RST   1'b0

`endif

/* shared/trp_ram_pkg.sv */
// types shared by the block memory modules
package trp_ram_pkg;

    // bit offset into the shared array
    typedef logic [11:0] trp_off_t;

    // last operation seen by a port, gray coded along idle-read-write
    typedef enum logic [1:0]
    {
        TRP_OP_IDLE  = 2'h0,
        TRP_OP_READ  = 2'h1,
        TRP_OP_WRITE = 2'h3
    } trp_op_e;

endpackage

/* hdl/trp_port_ctrl.sv */
// one memory port: input capture, bit offset and registered output
`timescale 1ns/1ns
`default_nettype none
`include "trp_ram_regs.svh"

module trp_port_ctrl
    import trp_ram_pkg::*;
#(
    parameter int unsigned W      = 16,
    parameter int unsigned AW     = $clog2(`TRP_MEM_BITS / W),
    parameter bit          ACTIVE = 1'b1
)
(
    // clock and reset
    input  wire logic          i_core_clk,
    input  wire logic          i_rst,
    // port control
    input  wire logic          i_clk_en,
    input  wire logic          i_en,
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_addr,
    input  wire logic [W-1:0]  i_din,
    input  wire logic [W-1:0]  i_rd_word,
    // to the array
    output logic               o_fire,
    output logic               o_wr,
    output trp_off_t           o_off,
    // registered results
    output logic [W-1:0]       o_dout,
    output trp_op_e            o_op
);

    localparam int unsigned LW = $clog2(W);

    // the port acts only on its own edge with enable high
    assign o_fire = ACTIVE && i_clk_en && i_en;
    assign o_wr   = o_fire && i_we;

    // narrow words are consecutive sub-fields of the wide layout
    assign o_off = trp_off_t'(trp_off_t'(i_addr) << LW);

    ////////////////////////////////////////////////////////////////////////
    // output register: the address never reaches the output unclocked
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            o_dout <= {W{`TRP_DOUT_RST}};
        else if (o_fire)
            o_dout <= i_we ? i_din : i_rd_word;
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            o_op <= TRP_OP_IDLE;
        else if (o_fire)
            o_op <= i_we ? TRP_OP_WRITE : TRP_OP_READ;
    end

endmodule // trp_port_ctrl

`default_nettype wire

/* verification/trp_fabric_port.sv */
// fabric-side driver model for one memory port
`timescale 1ns/1ns
`default_nettype none
`include "trp_ram_regs.svh"

module trp_fabric_port
#(
    parameter int unsigned W  = 16,
    parameter int unsigned AW = $clog2(`TRP_MEM_BITS / W)
)
(
    // clock and request
    input  wire logic          i_core_clk,
    input  wire logic          i_go,
    input  wire logic          i_ce,
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_addr,
    input  wire logic [W-1:0]  i_din,
    // to the memory port
    output logic               o_clk_en,
    output logic               o_en,
    output logic               o_we,
    output logic [AW-1:0]      o_addr,
    output logic [W-1:0]       o_din
);
    logic [AW-1:0] addr_q = '0;
    logic [W-1:0]  din_q  = '0;

    // released lines toggle so a stale value is never taken for a request
    always_ff @(posedge i_core_clk)
    begin
        addr_q <= ~o_addr;
        din_q  <= ~o_din;
    end
    assign o_clk_en = i_ce;
    assign o_en     = i_go;
    assign o_we     = i_go & i_we;
    assign o_addr   = i_go ? i_addr : addr_q;
    assign o_din    = i_go ? i_din : din_q;
endmodule // trp_fabric_port
`default_nettype wire

/* verification/trp_true_dual_port_block_ram_tb.sv */
// self-checking bench: 4-bit port a against 16-bit port b
`timescale 1ns/1ns
`default_nettype none

module trp_true_dual_port_block_ram_tb
    import trp_ram_pkg::*;
;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic a_go = 1'b0, a_ce = 1'b0, a_we = 1'b0, b_go = 1'b0, b_ce = 1'b0, b_we = 1'b0;
    logic [9:0] a_addr = '0;
    logic [3:0] a_din = '0;
    logic [7:0] b_addr = '0;
    logic [15:0] b_din = '0;
    logic a_cke, a_en, a_wr, b_cke, b_en, b_wr;
    logic [9:0] a_ad;
    logic [3:0] a_d, o_a_dout;
    logic [7:0] b_ad;
    logic [15:0] b_d, o_b_dout;
    trp_op_e o_a_op, o_b_op;
    logic [4095:0] mem;
    logic [5:0] ea;
    logic [17:0] eb;
    logic [5:0] qa[$];
    logic [17:0] qb[$];
    integer seed = 41787;
    int failures = 0;
    int check_count = 0;

    always #5 i_core_clk = ~i_core_clk;

    trp_fabric_port #(.W(4)) pa (.i_core_clk(i_core_clk), .i_go(a_go), .i_ce(a_ce),
        .i_we(a_we), .i_addr(a_addr), .i_din(a_din), .o_clk_en(a_cke), .o_en(a_en),
        .o_we(a_wr), .o_addr(a_ad), .o_din(a_d));
    trp_fabric_port #(.W(16)) pb (.i_core_clk(i_core_clk), .i_go(b_go), .i_ce(b_ce),
        .i_we(b_we), .i_addr(b_addr), .i_din(b_din), .o_clk_en(b_cke), .o_en(b_en),
        .o_we(b_wr), .o_addr(b_ad), .o_din(b_d));
    trp_true_dual_port_block_ram #(.A_W(4), .B_W(16)) uut (.i_core_clk(i_core_clk),
        .i_rst(i_rst), .i_a_clk_en(a_cke), .i_a_en(a_en), .i_a_we(a_wr), .i_a_addr(a_ad),
        .i_a_din(a_d), .o_a_dout(o_a_dout), .o_a_op(o_a_op), .i_b_clk_en(b_cke),
        .i_b_en(b_en), .i_b_we(b_wr), .i_b_addr(b_ad), .i_b_din(b_d),
        .o_b_dout(o_b_dout), .o_b_op(o_b_op));

    ////////////////////////////////////////////////////////////////////////
    task automatic compare(input logic [17:0] seen, input logic [17:0] exp, input string msg);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t ns: %s got %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d failures %0d", check_count, failures);
        if (check_count > 0 && failures == 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // one request per port; expectation uses contents before this edge
    task automatic step(input bit fill, input int n);
        logic ga, gb, ca, cb, wa, wb;
        logic [9:0] aa;
        logic [7:0] ab;
        logic [3:0] da;
        logic [15:0] db;
        ga = fill ? 1'b0 : 1'($random(seed));
        gb = fill | 1'($random(seed));
        ca = 1'($random(seed));
        cb = fill | 1'($random(seed));
        wa = 1'($random(seed));
        wb = fill | 1'($random(seed));
        aa = 10'($random(seed));
        ab = fill ? 8'(n) : 8'($random(seed));
        da = 4'($random(seed));
        db = 16'($random(seed));
        if (ga & ca & wa & gb & cb & wb & (aa[9:2] == ab))
            wa = 1'b0;
        if (ga & ca)
            ea = {wa ? TRP_OP_WRITE : TRP_OP_READ, wa ? da : mem[{aa, 2'h0} +: 4]};
        if (gb & cb)
            eb = {wb ? TRP_OP_WRITE : TRP_OP_READ, wb ? db : mem[{ab, 4'h0} +: 16]};
        if (ga & ca & wa)
            mem[{aa, 2'h0} +: 4] = da;
        if (gb & cb & wb)
            mem[{ab, 4'h0} +: 16] = db;
        qa.push_back(ea);
        qb.push_back(eb);
        a_go <= ga; a_ce <= ca; a_we <= wa; a_addr <= aa; a_din <= da;
        b_go <= gb; b_ce <= cb; b_we <= wb; b_addr <= ab; b_din <= db;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // the newest note belongs to the edge still to come, so it stays queued
    always @(posedge i_core_clk)
    begin
        #1;
        if (qa.size() > 1)
            compare({12'h000, o_a_op, o_a_dout}, {12'h000, qa.pop_front()}, "port a");
        if (qb.size() > 1)
            compare({o_b_op, o_b_dout}, qb.pop_front(), "port b");
    end

    initial
    begin
        ea = {TRP_OP_IDLE, 4'h0};
        eb = {TRP_OP_IDLE, 16'h0000};
        repeat (20) @(posedge i_core_clk);
        compare({12'h000, o_a_op, o_a_dout}, {12'h000, ea}, "reset a");
        compare({o_b_op, o_b_dout}, eb, "reset b");
        i_rst <= 1'b0;
        for (int n = 0; n < 256; n++)
        begin
            @(posedge i_core_clk);
            step(1'b1, n);
        end
        repeat (3000)
        begin
            @(posedge i_core_clk);
            step(1'b0, 0);
        end
        // idle tail: both ports quiet, outputs must keep the last result
        repeat (3)
        begin
            @(posedge i_core_clk);
            a_go <= 1'b0;
            b_go <= 1'b0;
            qa.push_back(ea);
            qb.push_back(eb);
        end
        @(posedge i_core_clk);
        #2;
        conclude();
    end

    initial
    begin
        #((20 + 256 + 3000 + 100) * 10);
        failures++;
        conclude();
    end
endmodule // trp_true_dual_port_block_ram_tb
`default_nettype wire
